// ---- design/cab_consts.svh ----
// constants for the arithmetic and branch execution subset
`ifndef CAB_CONSTS_SVH
`define CAB_CONSTS_SVH

`define CAB_DATA_W 16
`define CAB_TEN_BIT_LITERAL_W 10
`define CAB_FIVE_BIT_LITERAL_W 5
`define CAB_BIT4_W 4
`define CAB_NIBBLE_W 4
`define CAB_SIGN_BIT 15
`define CAB_FLAGS_RST 5'h00
`define CAB_EXTRA_NONE 2'h0
`define CAB_EXTRA_TAKEN 2'h1
`define CAB_EXTRA_SKIP_ONE 2'h1
`define CAB_EXTRA_SKIP_TWO 2'h2

`endif

// ---- design/cab_pkg.sv ----
// types for the arithmetic and branch execution subset
`include "cab_consts.svh"

package cab_pkg;

   // one-hot operation codes
   typedef enum logic [11:0] {
      OP_ADD      = 12'h001,
      OP_ADD_WITH_CARRY_OP     = 12'h002,
      OP_ASR1     = 12'h004,
      OP_ASRN     = 12'h008,
      OP_BRANCH   = 12'h010,
      OP_FLAG_ST  = 12'h020,
      OP_BIT_CLR  = 12'h040,
      OP_BIT_SET  = 12'h080,
      OP_BIT_TGL  = 12'h100,
      OP_SKIP_Z   = 12'h200,
      OP_SKIP_O   = 12'h400,
      OP_NONE     = 12'h800
   } cab_op_t;

   // branch conditions
   typedef enum logic [3:0] {
      CND_ALWAYS = 4'h0,
      CND_C      = 4'h1,
      CND_NC     = 4'h2,
      CND_N      = 4'h3,
      CND_NN     = 4'h4,
      CND_Z      = 4'h5,
      CND_NZ     = 4'h6,
      CND_GE     = 4'h7,
      CND_GT     = 4'h8,
      CND_LE     = 4'h9,
      CND_LT     = 4'hA,
      CND_GEU    = 4'hB,
      CND_GTU    = 4'hC,
      CND_LEU    = 4'hD,
      CND_LTU    = 4'hE
   } cab_cond_t;

   // second operand source
   typedef enum logic [1:0] {
      BSRC_REG   = 2'h0,
      BSRC_TEN_BIT_LITERAL = 2'h1,
      BSRC_FIVE_BIT_LITERAL  = 2'h2
   } cab_bsrc_t;

   typedef struct packed {
      logic n;
      logic ov;
      logic z;
      logic dc;
      logic c;
   } cab_flags_t;

   typedef struct packed {
      cab_op_t op;
      cab_cond_t cond;
      cab_bsrc_t bsrc;
      logic [`CAB_DATA_W-1:0] a;
      logic [`CAB_DATA_W-1:0] b;
      logic [`CAB_TEN_BIT_LITERAL_W-1:0] lit;
      logic [`CAB_BIT4_W-1:0] bidx;
      logic store_z;
      logic next_two_word;
   } cab_req_t;

endpackage

// ---- design/cab_cond_eval.sv ----
// branch condition evaluator over the status flags
`timescale 1ns/1ps

module cab_cond_eval (
   input wire cab_pkg::cab_cond_t cond,
   input wire cab_pkg::cab_flags_t flg,
   output logic taken
);

   // signed tests use n xor ov, unsigned tests use carry as not-borrow
   always_comb begin
      unique case (cond)
         cab_pkg::CND_ALWAYS: taken = 1'b1;
         cab_pkg::CND_C:      taken = flg.c;
         cab_pkg::CND_NC:     taken = ~flg.c;
         cab_pkg::CND_N:      taken = flg.n;
         cab_pkg::CND_NN:     taken = ~flg.n;
         cab_pkg::CND_Z:      taken = flg.z;
         cab_pkg::CND_NZ:     taken = ~flg.z;
         cab_pkg::CND_GE:     taken = ~(flg.n ^ flg.ov);
         cab_pkg::CND_GT:     taken = ~flg.z & ~(flg.n ^ flg.ov);
         cab_pkg::CND_LE:     taken = flg.z | (flg.n ^ flg.ov);
         cab_pkg::CND_LT:     taken = flg.n ^ flg.ov;
         cab_pkg::CND_GEU:    taken = flg.c;
         cab_pkg::CND_GTU:    taken = flg.c & ~flg.z;
         cab_pkg::CND_LEU:    taken = ~flg.c | flg.z;
         cab_pkg::CND_LTU:    taken = ~flg.c;
         default:             taken = 1'b0; // illegal code never branches
      endcase
   end

endmodule

// ---- design/cab_exec.sv ----
// execution unit for add, shift, branch, flag store, bit ops and skips
//
// Overview of operation
// - add and add-with-carry from any operand form, one cycle, sets C DC N OV Z
// - single arithmetic right shift keeps sign, one cycle, sets C N OV Z
// - multi-bit shift by register or literal count, one cycle, sets only N Z
// - signed conditional branches test flags, one cycle or two if taken
// - unsigned conditional branches share the one or two cycle timing
// - carry, negative and zero branches and their inverses, one or two cycles
// - unconditional branches always take two cycles, no flags
// - test-and-skip skips when selected bit is zero, flags untouched
// - test-and-skip skips when selected bit is one, flags untouched
`timescale 1ns/1ps
`include "cab_consts.svh"

module cab_exec (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic req_valid,
   input wire cab_pkg::cab_req_t req,
   output logic ready_ff,
   output logic done_ff,
   output logic wr_ff,
   output logic [`CAB_DATA_W-1:0] res_ff,
   output cab_pkg::cab_flags_t flags_ff,
   output logic redirect_ff,
   output logic [`CAB_DATA_W-1:0] offset_ff,
   output logic skip_ff
);

   logic accept;
   logic cond_taken;
   logic [`CAB_DATA_W-1:0] b_op;
   logic [`CAB_DATA_W:0] sum;
   logic [`CAB_NIBBLE_W:0] nib_sum;
   logic cin;
   logic [`CAB_DATA_W-1:0] mask;
   logic [`CAB_DATA_W-1:0] fmask;
   logic [`CAB_DATA_W-1:0] nxt_res;
   cab_pkg::cab_flags_t nxt_flags;
   logic nxt_wr;
   logic nxt_redirect;
   logic nxt_skip;
   logic [1:0] extra;
   logic [1:0] stall_ff;
   logic [1:0] nxt_stall;

   assign accept = req_valid & ready_ff;

   cab_cond_eval u_cond (
      .cond(req.cond),
      .flg(flags_ff),
      .taken(cond_taken)
   );

   // second operand from register or zero-extended literal
   always_comb begin
      unique case (req.bsrc)
         cab_pkg::BSRC_TEN_BIT_LITERAL: b_op = {6'h00, req.lit};
         cab_pkg::BSRC_FIVE_BIT_LITERAL:  b_op = {11'h000, req.lit[`CAB_FIVE_BIT_LITERAL_W-1:0]};
         default:             b_op = req.b;
      endcase
   end

   // shared adder, carry-in only for the carry variant
   assign cin = (req.op == cab_pkg::OP_ADD_WITH_CARRY_OP) ? flags_ff.c : 1'b0;
   assign sum = {1'b0, req.a} + {1'b0, b_op} + {16'h0000, cin};
   assign nib_sum = {1'b0, req.a[3:0]} + {1'b0, b_op[3:0]} + {4'h0, cin};
   assign mask = 16'h0001 << req.bidx;
   assign fmask = 16'h0001 << req.b[`CAB_BIT4_W-1:0];

   // result, flags, cost and redirect per operation
   always_comb begin
      nxt_res = res_ff;
      nxt_flags = flags_ff;
      nxt_wr = 1'b0;
      nxt_redirect = 1'b0;
      nxt_skip = 1'b0;
      extra = `CAB_EXTRA_NONE;
      unique case (req.op)
         cab_pkg::OP_ADD, cab_pkg::OP_ADD_WITH_CARRY_OP: begin
            nxt_res = sum[`CAB_DATA_W-1:0];
            nxt_wr = 1'b1;
            nxt_flags.c = sum[`CAB_DATA_W];
            nxt_flags.dc = nib_sum[`CAB_NIBBLE_W];
            nxt_flags.n = sum[`CAB_SIGN_BIT];
            nxt_flags.ov = (req.a[`CAB_SIGN_BIT] == b_op[`CAB_SIGN_BIT]) &
                           (sum[`CAB_SIGN_BIT] != req.a[`CAB_SIGN_BIT]);
            nxt_flags.z = (sum[`CAB_DATA_W-1:0] == 16'h0000);
         end
         cab_pkg::OP_ASR1: begin
            nxt_res = {req.a[`CAB_SIGN_BIT], req.a[`CAB_DATA_W-1:1]};
            nxt_wr = 1'b1;
            nxt_flags.c = req.a[0];
            nxt_flags.n = req.a[`CAB_SIGN_BIT];
            nxt_flags.ov = 1'b0; // sign is kept so no overflow can occur
            nxt_flags.z = (req.a[`CAB_DATA_W-1:1] == 15'h0000) & ~req.a[`CAB_SIGN_BIT];
         end
         cab_pkg::OP_ASRN: begin
            // counts above fifteen leave only sign copies, which is the natural answer
            nxt_res = $signed(req.a) >>> b_op[`CAB_FIVE_BIT_LITERAL_W-1:0];
            nxt_wr = 1'b1;
            nxt_flags.n = req.a[`CAB_SIGN_BIT];
            nxt_flags.z = (nxt_res == 16'h0000);
         end
         cab_pkg::OP_BRANCH: begin
            nxt_redirect = cond_taken;
            extra = cond_taken ? `CAB_EXTRA_TAKEN : `CAB_EXTRA_NONE;
         end
         cab_pkg::OP_FLAG_ST: begin
            // bit position comes from the low four bits of the selector register
            nxt_res = (req.store_z ? flags_ff.z : flags_ff.c) ? (req.a | fmask) :
                      (req.a & ~fmask);
            nxt_wr = 1'b1;
         end
         cab_pkg::OP_BIT_CLR: begin
            nxt_res = req.a & ~mask;
            nxt_wr = 1'b1;
         end
         cab_pkg::OP_BIT_SET: begin
            nxt_res = req.a | mask;
            nxt_wr = 1'b1;
         end
         cab_pkg::OP_BIT_TGL: begin
            nxt_res = req.a ^ mask;
            nxt_wr = 1'b1;
         end
         cab_pkg::OP_SKIP_Z, cab_pkg::OP_SKIP_O: begin
            nxt_skip = ((req.a & mask) == 16'h0000) ==
                       (req.op == cab_pkg::OP_SKIP_Z);
            if (nxt_skip) begin
               extra = req.next_two_word ? `CAB_EXTRA_SKIP_TWO :
                       `CAB_EXTRA_SKIP_ONE;
            end
         end
         default: begin
            nxt_res = res_ff; // illegal or empty op is a one-cycle no-op
         end
      endcase
   end

   // stall count: extra cycles after acceptance hold ready low
   assign nxt_stall = accept ? extra : ((stall_ff != 2'h0) ? stall_ff - 2'h1 : 2'h0);

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         stall_ff <= 2'h0;
         ready_ff <= 1'b1;
         done_ff <= 1'b0;
      end else begin
         stall_ff <= nxt_stall;
         ready_ff <= (nxt_stall == 2'h0);
         done_ff <= (accept & (extra == 2'h0)) | (stall_ff == 2'h1);
      end
   end

   // results and one-cycle event pulses
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         res_ff <= 16'h0000;
         wr_ff <= 1'b0;
         redirect_ff <= 1'b0;
         skip_ff <= 1'b0;
         offset_ff <= 16'h0000;
      end else begin
         wr_ff <= accept & nxt_wr;
         redirect_ff <= accept & nxt_redirect;
         skip_ff <= accept & nxt_skip;
         if (accept) begin
            res_ff <= nxt_res;
            offset_ff <= req.b;
         end
      end
   end

   // status flags change only for ops that own them
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         flags_ff <= `CAB_FLAGS_RST;
      end else if (accept) begin
         flags_ff <= nxt_flags;
      end
   end

   // checks
   a_add_result: assert property (@(posedge ref_clk) disable iff (rst)
      accept && req.op == cab_pkg::OP_ADD && req.bsrc == cab_pkg::BSRC_REG |=>
      res_ff == 16'($past(req.a) + $past(req.b)) && wr_ff && done_ff)
      else $error("add result or timing wrong");
   a_asr_sign_kept: assert property (@(posedge ref_clk) disable iff (rst)
      accept && req.op == cab_pkg::OP_ASR1 |=>
      res_ff[15] == $past(req.a[15]) && flags_ff.c == $past(req.a[0]) && !flags_ff.ov)
      else $error("single shift lost sign or carry");
   a_asrn_keeps_cv: assert property (@(posedge ref_clk) disable iff (rst)
      accept && req.op == cab_pkg::OP_ASRN |=>
      $stable(flags_ff.c) && $stable(flags_ff.ov) && $stable(flags_ff.dc))
      else $error("multi shift touched carry or overflow");
   a_taken_two_cyc: assert property (@(posedge ref_clk) disable iff (rst)
      accept && req.op == cab_pkg::OP_BRANCH && cond_taken |=>
      redirect_ff && !ready_ff && !done_ff ##1 ready_ff && done_ff)
      else $error("taken branch not two cycles");
   a_untaken_one: assert property (@(posedge ref_clk) disable iff (rst)
      accept && req.op == cab_pkg::OP_BRANCH && !cond_taken |=>
      !redirect_ff && ready_ff && done_ff)
      else $error("untaken branch not one cycle");
   a_zero_branch: assert property (@(posedge ref_clk) disable iff (rst)
      accept && req.op == cab_pkg::OP_BRANCH && req.cond == cab_pkg::CND_Z |=>
      redirect_ff == $past(flags_ff.z))
      else $error("zero branch decision wrong");
   a_uncond_flags: assert property (@(posedge ref_clk) disable iff (rst)
      accept && req.op == cab_pkg::OP_BRANCH && req.cond == cab_pkg::CND_ALWAYS |=>
      redirect_ff && $stable(flags_ff) ##1 done_ff)
      else $error("unconditional branch wrong");
   a_flag_store: assert property (@(posedge ref_clk) disable iff (rst)
      accept && req.op == cab_pkg::OP_FLAG_ST && !req.store_z |=>
      res_ff[$past(req.b[3:0])] == $past(flags_ff.c) && $stable(flags_ff))
      else $error("flag store wrong bit or value");
   a_skip_clear: assert property (@(posedge ref_clk) disable iff (rst)
      accept && req.op == cab_pkg::OP_SKIP_Z |=> skip_ff == !$past(req.a[req.bidx]))
      else $error("skip-if-zero decision wrong");
   a_skip_set: assert property (@(posedge ref_clk) disable iff (rst)
      accept && req.op == cab_pkg::OP_SKIP_O |=> skip_ff == $past(req.a[req.bidx]))
      else $error("skip-if-one decision wrong");
   a_skip_three: assert property (@(posedge ref_clk) disable iff (rst)
      accept && nxt_skip && req.next_two_word |=>
      !ready_ff ##1 !ready_ff ##1 ready_ff && done_ff)
      else $error("two-word skip not three cycles");
   a_bit_set_one: assert property (@(posedge ref_clk) disable iff (rst)
      accept && req.op == cab_pkg::OP_BIT_SET |=>
      res_ff == ($past(req.a) | (16'h0001 << $past(req.bidx))) && $stable(flags_ff))
      else $error("bit set altered other bits or flags");

   c_add_carry: cover property (@(posedge ref_clk) disable iff (rst)
      accept && req.op == cab_pkg::OP_ADD_WITH_CARRY_OP && flags_ff.c);
   c_branch_taken: cover property (@(posedge ref_clk) disable iff (rst)
      redirect_ff ##1 done_ff);
   c_skip_two_word: cover property (@(posedge ref_clk) disable iff (rst)
      accept && nxt_skip && req.next_two_word);

endmodule

// ---- test/cab_exec_tb.sv ----
// self-checking bench for the arithmetic and branch execution unit
`timescale 1ns/1ps

module cab_exec_tb;
   typedef struct {
      logic [15:0] res;
      logic [15:0] off;
      cab_pkg::cab_flags_t f;
      logic wr;
      logic rd;
      logic sk;
      int lat;
      time t;
   } cab_note_t;

   logic ref_clk;
   logic rst;
   logic req_valid;
   cab_pkg::cab_req_t req;
   logic ready_ff, done_ff, wr_ff, redirect_ff, skip_ff;
   logic [15:0] res_ff, offset_ff;
   cab_pkg::cab_flags_t flags_ff;
   cab_pkg::cab_flags_t mf;
   cab_note_t exp_q[$];
   int n_errors = 0;
   int total_checks = 0;
   integer seed = 45010;
   logic seen_rd = 1'b0;
   logic seen_sk = 1'b0;

   cab_exec dut (.ref_clk(ref_clk), .rst(rst), .req_valid(req_valid), .req(req),
      .ready_ff(ready_ff), .done_ff(done_ff), .wr_ff(wr_ff), .res_ff(res_ff),
      .flags_ff(flags_ff), .redirect_ff(redirect_ff), .offset_ff(offset_ff),
      .skip_ff(skip_ff));

   // 10 MHz core clock
   initial begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end

   // reference behaviour, flags taken as they stand at acceptance
   function automatic cab_note_t model(input cab_pkg::cab_req_t r, input cab_pkg::cab_flags_t f);
      cab_note_t n;
      logic [15:0] bo;
      logic [16:0] s;
      logic [4:0] s4;
      logic ci;
      logic tk;
      n.f = f;
      n.res = 16'h0000;
      n.off = r.b;
      n.wr = 1'b0;
      n.rd = 1'b0;
      n.sk = 1'b0;
      n.lat = 1;
      bo = (r.bsrc == cab_pkg::BSRC_TEN_BIT_LITERAL) ? {6'h00, r.lit} :
         (r.bsrc == cab_pkg::BSRC_FIVE_BIT_LITERAL) ? {11'h000, r.lit[4:0]} : r.b;
      ci = (r.op == cab_pkg::OP_ADD_WITH_CARRY_OP) & f.c;
      case (r.cond)
         cab_pkg::CND_ALWAYS: tk = 1'b1;
         cab_pkg::CND_C: tk = f.c;
         cab_pkg::CND_NC: tk = !f.c;
         cab_pkg::CND_N: tk = f.n;
         cab_pkg::CND_NN: tk = !f.n;
         cab_pkg::CND_Z: tk = f.z;
         cab_pkg::CND_NZ: tk = !f.z;
         cab_pkg::CND_GE: tk = (f.n == f.ov);
         cab_pkg::CND_GT: tk = !f.z && (f.n == f.ov);
         cab_pkg::CND_LE: tk = f.z || (f.n != f.ov);
         cab_pkg::CND_LT: tk = (f.n != f.ov);
         cab_pkg::CND_GEU: tk = f.c;
         cab_pkg::CND_GTU: tk = f.c && !f.z;
         cab_pkg::CND_LEU: tk = !f.c || f.z;
         cab_pkg::CND_LTU: tk = !f.c;
         default: tk = 1'b0;
      endcase
      case (r.op)
         cab_pkg::OP_ADD, cab_pkg::OP_ADD_WITH_CARRY_OP: begin
            s = {1'b0, r.a} + {1'b0, bo} + {16'h0000, ci};
            s4 = {1'b0, r.a[3:0]} + {1'b0, bo[3:0]} + {4'h0, ci};
            n.res = s[15:0];
            n.f.c = s[16];
            n.f.dc = s4[4];
            n.f.ov = (r.a[15] == bo[15]) && (s[15] != r.a[15]);
         end
         cab_pkg::OP_ASR1: begin
            n.res = {r.a[15], r.a[15:1]};
            n.f.c = r.a[0];
            n.f.ov = 1'b0;
         end
         cab_pkg::OP_ASRN: n.res = 16'($signed(r.a) >>> bo[4:0]);
         cab_pkg::OP_BRANCH: begin
            n.rd = tk;
            n.lat = tk ? 2 : 1;
         end
         cab_pkg::OP_FLAG_ST: begin
            n.res = r.a;
            n.res[r.b[3:0]] = r.store_z ? f.z : f.c;
         end
         cab_pkg::OP_BIT_CLR: begin
            n.res = r.a;
            n.res[r.bidx] = 1'b0;
         end
         cab_pkg::OP_BIT_SET: begin
            n.res = r.a;
            n.res[r.bidx] = 1'b1;
         end
         cab_pkg::OP_BIT_TGL: begin
            n.res = r.a;
            n.res[r.bidx] = !r.a[r.bidx];
         end
         cab_pkg::OP_SKIP_Z, cab_pkg::OP_SKIP_O: begin
            n.sk = (r.a[r.bidx] == (r.op == cab_pkg::OP_SKIP_O));
            n.lat = n.sk ? (r.next_two_word ? 3 : 2) : 1;
         end
         default: n.lat = 1;
      endcase
      n.wr = r.op inside {cab_pkg::OP_ADD, cab_pkg::OP_ADD_WITH_CARRY_OP, cab_pkg::OP_ASR1,
         cab_pkg::OP_ASRN, cab_pkg::OP_FLAG_ST, cab_pkg::OP_BIT_CLR,
         cab_pkg::OP_BIT_SET, cab_pkg::OP_BIT_TGL};
      if (r.op inside {cab_pkg::OP_ADD, cab_pkg::OP_ADD_WITH_CARRY_OP, cab_pkg::OP_ASR1,
            cab_pkg::OP_ASRN}) begin
         n.f.n = n.res[15];
         n.f.z = (n.res == 16'h0000);
      end
      return n;
   endfunction

   task automatic chk_w(input logic [15:0] g, input logic [15:0] e, input string m);
      total_checks++;
      if (g !== e) begin
         n_errors++;
         $display("wrong value at %0t: %s got %h exp %h", $time, m, g, e);
      end
   endtask

   task automatic chk_f(input cab_pkg::cab_flags_t g, input cab_pkg::cab_flags_t e);
      total_checks++;
      if (g !== e) begin
         n_errors++;
         $display("wrong value at %0t: flags got %b exp %b", $time, g, e);
      end
   endtask

   task automatic chk_b(input logic g, input logic e, input string m);
      total_checks++;
      if (g !== e) begin
         n_errors++;
         $display("wrong value at %0t: %s got %b exp %b", $time, m, g, e);
      end
   endtask

   task automatic chk_n(input int g, input int e, input string m);
      total_checks++;
      if (g != e) begin
         n_errors++;
         $display("wrong value at %0t: %s got %0d exp %0d", $time, m, g, e);
      end
   endtask

   task automatic close_out();
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // holds the request until an edge sees ready, then files the expectation
   task automatic go(input cab_pkg::cab_req_t r);
      cab_note_t n;
      int k;
      req_valid <= 1'b1;
      req <= r;
      k = 0;
      do begin
         @(posedge ref_clk);
         k++;
      end while (ready_ff !== 1'b1 && k < 10);
      // a stall that never ends counts as a mismatch instead of hanging the run
      if (ready_ff !== 1'b1) chk_b(ready_ff, 1'b1, "ready wait");
      n = model(r, mf);
      mf = n.f;
      n.t = $time;
      exp_q.push_back(n);
   endtask

   task automatic dir(input cab_pkg::cab_op_t o, input cab_pkg::cab_cond_t cd,
         input cab_pkg::cab_bsrc_t bs, input logic [15:0] a, input logic [15:0] b,
         input logic [9:0] l, input logic [3:0] bi, input logic tw);
      cab_pkg::cab_req_t r;
      r = '0;
      r.op = o;
      r.cond = cd;
      r.bsrc = bs;
      r.a = a;
      r.b = b;
      r.lit = l;
      r.bidx = bi;
      r.store_z = b[4];
      r.next_two_word = tw;
      go(r);
   endtask

   // results are judged at the done pulse; pulses between dones are collected
   always @(negedge ref_clk) begin
      cab_note_t n;
      if (rst === 1'b0) begin
         seen_rd = seen_rd | redirect_ff;
         seen_sk = seen_sk | skip_ff;
         if (done_ff === 1'b1) begin
            if (exp_q.size() == 0) begin
               chk_n(1, 0, "unexpected done");
            end else begin
               n = exp_q.pop_front();
               chk_b(wr_ff, n.wr, "write back");
               if (n.wr) chk_w(res_ff, n.res, "result");
               chk_f(flags_ff, n.f);
               chk_w(offset_ff, n.off, "offset");
               chk_b(ready_ff, 1'b1, "ready at done");
               chk_b(seen_rd, n.rd, "redirect");
               chk_b(seen_sk, n.sk, "skip");
               chk_n(int'(($time - n.t + 50) / 100), n.lat, "cycles");
            end
            seen_rd = 1'b0;
            seen_sk = 1'b0;
         end
      end
   end

   // watchdog well past the expected run of about five hundred cycles
   initial begin
      #2000000;
      n_errors++;
      close_out();
   end

   initial begin
      cab_pkg::cab_op_t ops[13];
      cab_pkg::cab_req_t r;
      logic [95:0] tmp;
      ops = '{cab_pkg::OP_ADD, cab_pkg::OP_ADD_WITH_CARRY_OP, cab_pkg::OP_ASR1, cab_pkg::OP_ASRN,
         cab_pkg::OP_BRANCH, cab_pkg::OP_FLAG_ST, cab_pkg::OP_BIT_CLR, cab_pkg::OP_BIT_SET,
         cab_pkg::OP_BIT_TGL, cab_pkg::OP_SKIP_Z, cab_pkg::OP_SKIP_O, cab_pkg::OP_NONE,
         cab_pkg::cab_op_t'(12'h000)};
      rst = 1'b1;
      req_valid = 1'b0;
      req = '0;
      mf = '0;
      repeat (8) @(posedge ref_clk);
      rst <= 1'b0;
      @(posedge ref_clk);
      chk_f(flags_ff, '0);
      // carry, half carry, overflow and zero corners, every operand form
      dir(cab_pkg::OP_ADD, cab_pkg::CND_ALWAYS, cab_pkg::BSRC_REG,
         16'h7FFF, 16'h0001, 10'h000, 4'h0, 1'b0);
      dir(cab_pkg::OP_ADD, cab_pkg::CND_ALWAYS, cab_pkg::BSRC_REG,
         16'hFFFF, 16'h0001, 10'h000, 4'h0, 1'b0);
      dir(cab_pkg::OP_ADD_WITH_CARRY_OP, cab_pkg::CND_ALWAYS, cab_pkg::BSRC_TEN_BIT_LITERAL,
         16'h000F, 16'h0000, 10'h3FF, 4'h0, 1'b0);
      dir(cab_pkg::OP_ADD, cab_pkg::CND_ALWAYS, cab_pkg::BSRC_FIVE_BIT_LITERAL,
         16'h0001, 16'h0000, 10'h3FF, 4'h0, 1'b0);
      dir(cab_pkg::OP_ASR1, cab_pkg::CND_ALWAYS, cab_pkg::BSRC_REG,
         16'h8001, 16'h0000, 10'h000, 4'h0, 1'b0);
      dir(cab_pkg::OP_ASRN, cab_pkg::CND_ALWAYS, cab_pkg::BSRC_REG,
         16'h8000, 16'h0010, 10'h000, 4'h0, 1'b0);
      dir(cab_pkg::OP_ASRN, cab_pkg::CND_ALWAYS, cab_pkg::BSRC_FIVE_BIT_LITERAL,
         16'h4000, 16'h0000, 10'h00F, 4'h0, 1'b0);
      // every branch condition under four flag settings; GTU is never taken, ALWAYS and LEU always are
      for (int j = 0; j < 4; j++) begin
         dir(cab_pkg::OP_ADD, cab_pkg::CND_ALWAYS, cab_pkg::BSRC_REG, j[0] ? 16'h7FFF : 16'hFFFF,
            {15'h0000, j[1]}, 10'h000, 4'h0, 1'b0);
         for (int i = 0; i < 16; i++) begin
            dir(cab_pkg::OP_BRANCH, cab_pkg::cab_cond_t'(i), cab_pkg::BSRC_REG, 16'h0000,
               16'hA5C3 ^ 16'(i), 10'h000, 4'h0, 1'b0);
         end
      end
      // skips over one and two word instructions, both outcomes, back to back
      for (int i = 0; i < 8; i++) begin
         dir(i[2] ? cab_pkg::OP_SKIP_O : cab_pkg::OP_SKIP_Z, cab_pkg::CND_ALWAYS,
            cab_pkg::BSRC_REG, 16'h00F0, 16'h0000, 10'h000,
            i[1] ? 4'h4 : 4'h0, i[0]);
      end
      // random mix, including an op code that is not one-hot
      repeat (300) begin
         tmp = {$random(seed), $random(seed), $random(seed)};
         r = tmp[65:0];
         r.op = ops[$unsigned($random(seed)) % 13];
         r.bsrc = cab_pkg::cab_bsrc_t'(2'($unsigned(r.bsrc) % 3));
         go(r);
      end
      req_valid <= 1'b0;
      repeat (5) @(posedge ref_clk);
      chk_n(exp_q.size(), 0, "pending results");
      close_out();
   end
endmodule
